// >>> dv/usbotg_hw_model.sv
// Controller-side model driving the pull requests.
// Assumes requests on the block clock, no synchroniser.
`timescale 1ns/1ps
`default_nettype none
module usbotg_hw_model (
    input  wire logic                     aclk,
    input  wire usbotg_pkg::usbotg_pull_t req,
    output var  usbotg_pkg::usbotg_pull_t hw_pull
);
    import usbotg_pkg::*;
    // Registered, as a real same-clock source
    always_ff @(posedge aclk) begin
        hw_pull <= req;
    end
endmodule : usbotg_hw_model
`default_nettype wire

// >>> dv/usbotg_line_ctrl_bench.sv
// Bench for the line control block over AXI4-Lite.
// Assumes design, package, model and checker compiled first.
`timescale 1ns/1ps
`default_nettype none
module usbotg_line_ctrl_bench;
    import usbotg_pkg::*;
    logic aclk = 1'h0, aresetn = 1'h0;
    logic [11:0] s_axi_awaddr = 12'h000, s_axi_araddr = 12'h000;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
    logic [3:0] s_axi_wstrb = 4'hF;
    logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
    logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0, s_axi_rvalid;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    usbotg_pull_t req = 4'h0, hw_pull, line_pull;
    usbotg_vbus_t line_vbus;
    int fails = 0, cmp_count = 0, cyc = 0;
    logic [7:0] d;
    always #2 aclk = ~aclk;
    usbotg_line_ctrl usbotg_line_ctrl_inst (.*);
    usbotg_hw_model usbotg_hw_model_inst (.aclk(aclk), .req(req),
        .hw_pull(hw_pull));
    task automatic chk(input logic [31:0] s, input logic [31:0] e);
        cmp_count++;
        if (s !== e) begin
            fails++;
            $display("[FAIL] %0t saw %h expected %h", $time, s, e);
        end
    endtask : chk
    task automatic wr(input logic [11:0] a, input logic [7:0] v,
                      input logic [1:0] r);
        logic ga = 1'h0, gw = 1'h0;
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= {24'hFFFFFF, v};
        s_axi_awvalid <= 1'h1;
        s_axi_wvalid <= 1'h1;
        s_axi_bready <= 1'h1;
        do begin
            @(posedge aclk);
            ga |= s_axi_awready & s_axi_awvalid;
            gw |= s_axi_wready & s_axi_wvalid;
            s_axi_awvalid <= !ga;
            s_axi_wvalid <= !gw;
        end while (!(ga && gw));
        do @(posedge aclk); while (!s_axi_bvalid);
        s_axi_bready <= 1'h0;
        chk({30'h0, s_axi_bresp}, {30'h0, r});
    endtask : wr
    task automatic rd(input logic [11:0] a, input logic [31:0] e,
                      input logic [1:0] r);
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'h1;
        s_axi_rready <= 1'h1;
        do @(posedge aclk); while (!s_axi_arready);
        s_axi_arvalid <= 1'h0;
        do @(posedge aclk); while (!s_axi_rvalid);
        s_axi_rready <= 1'h0;
        chk(s_axi_rdata, e);
        chk({30'h0, s_axi_rresp}, {30'h0, r});
    endtask : rd
    task automatic conclude;
        $display("Compares %0d, mismatches %0d", cmp_count, fails);
        if (fails == 0 && cmp_count > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : conclude
    // Whole run needs well under this many cycles
    always @(posedge aclk) begin
        cyc <= cyc + 1;
        if (cyc == 3000) begin
            fails = fails + 1;
            conclude();
        end
    end
    initial begin
        repeat (6) @(posedge aclk);
        aresetn <= 1'h1;
        rd(12'h000, 32'h0, 2'h0);
        chk({25'h0, line_pull, line_vbus}, 32'h0);
        req <= 4'h9;
        repeat (3) @(posedge aclk);
        chk({28'h0, line_pull}, 32'h9);
        for (int i = 0; i < 8; i++) begin
            d = (8'h01 << i) | 8'h04;
            wr(12'h000, d, 2'h0);
            rd(12'h000, {24'h0, d}, 2'h0);
            chk({25'h0, line_pull, line_vbus},
                {25'h0, d[7:4], d[3], d[1:0]});
        end
        wr(12'h000, 8'h0B, 2'h0);
        chk({28'h0, line_pull}, 32'h9);
        req <= 4'h6;
        repeat (3) @(posedge aclk);
        chk({28'h0, line_pull}, 32'h6);
        // Lane 0 off: control byte must survive
        s_axi_wstrb <= 4'hE;
        wr(12'h000, 8'hF4, 2'h0);
        s_axi_wstrb <= 4'hF;
        chk({28'h0, line_pull}, 32'h6);
        wr(12'h010, 8'hFF, 2'h2);
        rd(12'h010, 32'h0, 2'h2);
        rd(12'h000, 32'h0B, 2'h0);
        conclude();
    end
endmodule : usbotg_line_ctrl_bench
`default_nettype wire

// >>> dv/usbotg_line_ctrl_checker.sv
// Port checker for the line control block.
// Assumes one write at a time; only byte lane 0 holds control bits.
`timescale 1ns/1ps
`default_nettype none
module usbotg_line_ctrl_checker (
    input wire logic        aclk,
    input wire logic        aresetn,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0]  s_axi_wstrb,
    input wire logic        s_axi_wvalid,
    input wire logic        s_axi_wready,
    input wire logic        s_axi_bvalid,
    input wire logic [1:0]  s_axi_bresp,
    input wire logic        s_axi_bready,
    input wire logic        s_axi_rvalid,
    input wire logic        s_axi_rready,
    input wire logic [31:0] s_axi_rdata,
    input wire usbotg_pkg::usbotg_pull_t hw_pull,
    input wire usbotg_pkg::usbotg_pull_t line_pull,
    input wire usbotg_pkg::usbotg_vbus_t line_vbus
);
    import usbotg_pkg::*;
    logic [7:0] wd, sh, shn;
    logic       pbv, cm;
    // Shadow byte; only an OKAY response commits
    assign cm  = s_axi_bvalid & ~pbv & (s_axi_bresp == 2'h0);
    assign shn = cm ? wd : sh;
    always_ff @(posedge aclk) begin
        // Lane 0 strobe off keeps the old control byte
        if (s_axi_wvalid & s_axi_wready) begin
            wd <= s_axi_wstrb[0] ? s_axi_wdata[7:0] : sh;
        end
        pbv <= aresetn & s_axi_bvalid;
        sh  <= aresetn ? shn : 8'h00;
    end
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    a_vbus_map: assert property (
        $past(aresetn) |-> line_vbus == {shn[3], shn[1], shn[0]})
        else $error("vbus outputs differ from control");
    a_pull_sw: assert property (
        shn[2] |-> line_pull == shn[7:4])
        else $error("software pulls not on outputs");
    a_pull_hw: assert property (
        $past(aresetn) && !shn[2] |-> line_pull == $past(hw_pull))
        else $error("hardware pulls not on outputs");
    a_rd_hi: assert property (
        s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0)
        else $error("upper read bits not zero");
    a_rst_clear: assert property (
        $rose(aresetn) |-> line_pull == 4'h0 && line_vbus == 3'h0)
        else $error("outputs not cleared by reset");
    a_w_refuse: assert property (s_axi_bvalid |-> !s_axi_wready)
        else $error("write data taken while response open");
    a_b_once: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
        else $error("write response repeated");
    a_r_once: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
        else $error("read response repeated");
endmodule : usbotg_line_ctrl_checker
bind usbotg_line_ctrl usbotg_line_ctrl_checker usbotg_line_ctrl_checker_inst (.*);
`default_nettype wire

// >>> rtl/usbotg_defs.svh
// Constants for the USB line termination control block.
// Assumes inclusion by bare name from rtl/ design files.
`ifndef USBOTG_DEFS_SVH
`define USBOTG_DEFS_SVH

`define USBOTG_ADDR_W         12
`define USBOTG_CTRL_OFFSET    12'h000
`define USBOTG_CTRL_W         8
`define USBOTG_CTRL_RESET     8'h00
`define USBOTG_BIT_DP_PU      7
`define USBOTG_BIT_DM_PU      6
`define USBOTG_BIT_DP_PD      5
`define USBOTG_BIT_DM_PD      4
`define USBOTG_BIT_VBUS_ON    3
`define USBOTG_BIT_OVERRIDE   2
`define USBOTG_BIT_CHARGE     1
`define USBOTG_BIT_DISCHARGE  0
`define USBOTG_PULL_LSB       4
`define USBOTG_PULL_MSB       7
`define USBOTG_RESP_OKAY      2'h0
`define USBOTG_RESP_SLVERR    2'h2

`endif

// >>> rtl/usbotg_line_ctrl.sv
// USB line termination and VBUS control, AXI4-Lite slave top.
// Assumes one clock; hardware pull requests are on that clock.
//
// Behaviour
// - Bits 31 to 8 read as zero
// - Bit 7 drives D+ pull-up enable
// - Bit 6 drives D- pull-up enable
// - Bit 5 drives D+ pull-down enable
// - Bit 4 drives D- pull-down enable
// - Bit 3 powers VBUS
// - Override one: pulls follow register bits
// - Override zero: pulls follow USB hardware
// - Bit 1 charges VBUS through resistor
// - Bit 0 discharges VBUS through resistor
//
// The address map and the AXI4-Lite interface to the registers were left to the implementer.
`include "usbotg_defs.svh"
`timescale 1ns/1ps
`default_nettype none

module usbotg_line_ctrl #(
    parameter int ADDR_W = `USBOTG_ADDR_W
) (
    input  wire logic                     aclk,
    input  wire logic                     aresetn,
    input  wire logic [ADDR_W-1:0]        s_axi_awaddr,
    input  wire logic                     s_axi_awvalid,
    output wire logic                     s_axi_awready,
    input  wire logic [31:0]              s_axi_wdata,
    input  wire logic [3:0]               s_axi_wstrb,
    input  wire logic                     s_axi_wvalid,
    output wire logic                     s_axi_wready,
    output wire logic [1:0]               s_axi_bresp,
    output wire logic                     s_axi_bvalid,
    input  wire logic                     s_axi_bready,
    input  wire logic [ADDR_W-1:0]        s_axi_araddr,
    input  wire logic                     s_axi_arvalid,
    output wire logic                     s_axi_arready,
    output wire logic [31:0]              s_axi_rdata,
    output wire logic [1:0]               s_axi_rresp,
    output wire logic                     s_axi_rvalid,
    input  wire logic                     s_axi_rready,
    input  wire usbotg_pkg::usbotg_pull_t hw_pull,
    output wire usbotg_pkg::usbotg_pull_t line_pull,
    output wire usbotg_pkg::usbotg_vbus_t line_vbus
);
    import usbotg_pkg::*;

    usbotg_state_t s_reg;
    usbotg_state_t s_next;
    logic [31:0]   cur_word;
    logic [31:0]   merged;
    usbotg_pull_t  sw_pull;
    usbotg_pull_t  pull_sel;
    logic [7:0]    ctrl_new;
    logic          wr_hit;
    logic          rd_hit;

    // Only the low 8 bits exist; upper bits read as zero
    assign cur_word = {24'h000000, s_reg.ctrl};

    usbotg_wmerge u_wmerge (
        .old_word (cur_word),
        .wdata    (s_reg.w_data),
        .wstrb    (s_reg.w_strb),
        .merged   (merged)
    );

    // Word compare; address bits 1:0 ignored
    assign wr_hit = s_reg.aw_addr[ADDR_W-1:2] ==
                    (ADDR_W-2)'(`USBOTG_CTRL_OFFSET >> 2);
    assign rd_hit = s_axi_araddr[ADDR_W-1:2] ==
                    (ADDR_W-2)'(`USBOTG_CTRL_OFFSET >> 2);

    // Write commits when address and data are both held
    always_comb begin
        ctrl_new = s_reg.ctrl;
        if (s_reg.aw_got && s_reg.w_got && !s_reg.bvalid && wr_hit) begin
            ctrl_new = merged[7:0];
        end
    end

    // Pull bits 7..4 in register order
    assign sw_pull = ctrl_new[`USBOTG_PULL_MSB:`USBOTG_PULL_LSB];

    usbotg_pull_sel u_pull_sel (
        .pull_sw_override (ctrl_new[`USBOTG_BIT_OVERRIDE]),
        .sw_pull          (sw_pull),
        .hw_pull          (hw_pull),
        .pull_sel         (pull_sel)
    );

    always_comb begin
        s_next = s_reg;
        // Address and data accepted in either order
        if (s_axi_awvalid && s_reg.awready) begin
            s_next.aw_addr = 12'(s_axi_awaddr);
            s_next.aw_got  = 1'b1;
            s_next.awready = 1'b0;
        end
        if (s_axi_wvalid && s_reg.wready) begin
            s_next.w_data = s_axi_wdata;
            s_next.w_strb = s_axi_wstrb;
            s_next.w_got  = 1'b1;
            s_next.wready = 1'b0;
        end
        if (s_reg.aw_got && s_reg.w_got && !s_reg.bvalid) begin
            s_next.bvalid = 1'b1;
            s_next.bresp  = wr_hit ? `USBOTG_RESP_OKAY
                                   : `USBOTG_RESP_SLVERR;
            s_next.aw_got = 1'b0;
            s_next.w_got  = 1'b0;
        end
        // Ready stays low until the response is taken: one write at a time
        if (s_reg.bvalid && s_axi_bready) begin
            s_next.bvalid  = 1'b0;
            s_next.awready = 1'b1;
            s_next.wready  = 1'b1;
        end
        if (s_axi_arvalid && s_reg.arready) begin
            s_next.arready = 1'b0;
            s_next.rvalid  = 1'b1;
            s_next.rdata   = rd_hit ? cur_word : 32'h00000000;
            s_next.rresp   = rd_hit ? `USBOTG_RESP_OKAY
                                    : `USBOTG_RESP_SLVERR;
        end
        if (s_reg.rvalid && s_axi_rready) begin
            s_next.rvalid  = 1'b0;
            s_next.arready = 1'b1;
        end
        s_next.ctrl = ctrl_new;
        // Pins registered so they change with the control bits
        s_next.pull = pull_sel;
        s_next.vbus.vbus_supply_on    = ctrl_new[`USBOTG_BIT_VBUS_ON];
        s_next.vbus.vbus_charge_en    = ctrl_new[`USBOTG_BIT_CHARGE];
        s_next.vbus.vbus_discharge_en = ctrl_new[`USBOTG_BIT_DISCHARGE];
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_reg         <= '0;
            s_reg.ctrl    <= `USBOTG_CTRL_RESET;
            s_reg.awready <= 1'b1;
            s_reg.wready  <= 1'b1;
            s_reg.arready <= 1'b1;
        end else begin
            s_reg <= s_next;
        end
    end

    assign s_axi_awready = s_reg.awready;
    assign s_axi_wready  = s_reg.wready;
    assign s_axi_bvalid  = s_reg.bvalid;
    assign s_axi_bresp   = s_reg.bresp;
    assign s_axi_arready = s_reg.arready;
    assign s_axi_rvalid  = s_reg.rvalid;
    assign s_axi_rresp   = s_reg.rresp;
    assign s_axi_rdata   = s_reg.rdata;
    assign line_pull     = s_reg.pull;
    assign line_vbus     = s_reg.vbus;

endmodule : usbotg_line_ctrl

`default_nettype wire

// >>> rtl/usbotg_pkg.sv
// Types shared by the USB line termination control block.
// Assumes usbotg_defs.svh is compiled alongside.
package usbotg_pkg;

    // Order matches control bits 7 down to 4
    typedef struct packed {
        logic dplus_pullup_en;
        logic dminus_pullup_en;
        logic dplus_pulldown_en;
        logic dminus_pulldown_en;
    } usbotg_pull_t;

    typedef struct packed {
        logic vbus_supply_on;
        logic vbus_charge_en;
        logic vbus_discharge_en;
    } usbotg_vbus_t;

    typedef struct packed {
        logic         awready;
        logic         wready;
        logic         bvalid;
        logic [1:0]   bresp;
        logic         arready;
        logic         rvalid;
        logic [1:0]   rresp;
        logic [31:0]  rdata;
        logic [11:0]  aw_addr;
        logic         aw_got;
        logic [31:0]  w_data;
        logic [3:0]   w_strb;
        logic         w_got;
        logic [7:0]   ctrl;
        usbotg_pull_t pull;
        usbotg_vbus_t vbus;
    } usbotg_state_t;

endpackage : usbotg_pkg

// >>> rtl/usbotg_pull_sel.sv
// Selects the source of the four data-line pull enables.
// Assumes hardware requests come from logic on the same clock.
`timescale 1ns/1ps
`default_nettype none

module usbotg_pull_sel (
    input  wire logic                   pull_sw_override,
    input  wire usbotg_pkg::usbotg_pull_t sw_pull,
    input  wire usbotg_pkg::usbotg_pull_t hw_pull,
    output var  usbotg_pkg::usbotg_pull_t pull_sel
);
    import usbotg_pkg::*;
    logic [3:0] sw_v;
    logic [3:0] hw_v;
    logic [3:0] sel_v;

    assign sw_v = sw_pull;
    assign hw_v = hw_pull;

    genvar i;
    generate
        for (i = 0; i < 4; i = i + 1) begin : g_pull
            // Software or controller drives each pull
            assign sel_v[i] = pull_sw_override ? sw_v[i] : hw_v[i];
        end
    endgenerate

    assign pull_sel = sel_v;
endmodule : usbotg_pull_sel

`default_nettype wire

// >>> rtl/usbotg_wmerge.sv
// Byte-strobe merge of AXI write data onto a stored word.
// Assumes a 32-bit data path with one strobe per byte.
`timescale 1ns/1ps
`default_nettype none

module usbotg_wmerge (
    input  wire logic [31:0] old_word,
    input  wire logic [31:0] wdata,
    input  wire logic [3:0]  wstrb,
    output wire logic [31:0] merged
);
    genvar i;
    generate
        for (i = 0; i < 4; i = i + 1) begin : g_byte
            assign merged[8*i +: 8] = wstrb[i] ? wdata[8*i +: 8]
                                               : old_word[8*i +: 8];
        end
    endgenerate
endmodule : usbotg_wmerge

`default_nettype wire
